// ===== dv/cis_src_model.sv
// model of slot and onboard sources driving the pci request lines
`timescale 1ns/10ps
module cis_src_model (
	// requests from the bench, active high
	input wire logic [cis_pkg::PCI_INPUTS-1:0] i_req,
	// request lines toward the steering block
	output logic [cis_pkg::PCI_INPUTS-1:0] o_pci_int_b
);
	// one private line per source, held low while service is wanted
	assign o_pci_int_b = ~i_req;
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the interrupt steering top
`timescale 1ns/10ps
module tb_top;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [15:0] isa = 16'h0100;
	logic [48:0] req = '0;
	logic [48:0] pci_b;
	logic [6:0] crit = 7'h00;
	logic apic = 1'b0;
	logic [6:0] en = 7'h00;
	logic [6:0] map = 7'h00;
	logic intr, aval, sm, nmi;
	logic [7:0] ivec, avec;
	logic [64:0] pend;
	int fail_count = 0;
	int num_checks = 0;
	always #50 i_clk = ~i_clk;
	cis_src_model i_src (.i_req(req), .o_pci_int_b(pci_b));
	cis_top i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_isa_irq(isa), .i_pci_int_b(pci_b),
		.i_crit_src(crit), .i_apic_mode(apic), .i_smi_en(en), .i_nmi_map_en(map),
		.o_intr(intr), .o_intr_vector(ivec), .o_apic_valid(aval), .o_apic_vector(avec),
		.o_pending(pend), .o_system_management_interrupt(sm), .o_nmi(nmi));
	task automatic check(input logic [71:0] seen, input logic [71:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// levels only, so three edges covers every documented latency
	task automatic settle();
		repeat (3) @(posedge i_clk);
		#1;
	endtask
	task automatic test_reset();
		check(pend, 65'h0);
		check({intr, aval, sm, nmi}, 4'h0);
	endtask
	// walk every pci line, each replacing the last so a release shows too
	task automatic test_pci();
		@(posedge i_clk);
		apic <= 1'b1;
		for (int i = 0; i < 49; i++) begin
			@(posedge i_clk);
			req <= 49'h1 << i;
			settle();
			check(pend, (i == 47) ? 65'h0 : 65'h1 << (i + 16));
			check({aval, intr}, (i == 47) ? 2'h0 : 2'h2);
			if (i != 47)
				check(avec, i + 16);
		end
		@(posedge i_clk);
		req <= (49'h1 << 30) | (49'h1 << 5);
		settle();
		check(avec, 8'h15);
		@(posedge i_clk);
		req <= '0;
		settle();
		check({pend, aval}, 66'h0);
	endtask
	task automatic test_isa();
		@(posedge i_clk);
		apic <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			@(posedge i_clk);
			isa <= 16'h0100 ^ (16'h1 << i);
			settle();
			check(pend, (i == 0) ? 65'h0 : 65'h1 << i);
			check({intr, aval}, (i == 0) ? 2'h0 : 2'h2);
			if (i != 0)
				check(ivec, i);
		end
		@(posedge i_clk);
		isa <= 16'h0100;
	endtask
	// enables off prove the nmi path stands apart from the management path
	task automatic test_crit();
		logic [6:0] ens [3] = '{7'h7f, 7'h00, 7'h7f};
		logic [6:0] maps [3] = '{7'h7f, 7'h7f, 7'h00};
		for (int p = 0; p < 3; p++) begin
			for (int s = 0; s < 7; s++) begin
				@(posedge i_clk);
				en <= ens[p];
				map <= maps[p];
				crit <= 7'h1 << s;
				settle();
				check(sm, ens[p][s]);
				check(nmi, maps[p][s] & cis_pkg::NMI_MAP_ALLOWED[s]);
			end
		end
		@(posedge i_clk);
		crit <= 7'h00;
		en <= 7'h01;
		req <= 49'h1 << 46;
		settle();
		check({sm, nmi}, 2'h2);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		conclude();
	end
	initial begin
		repeat (5) @(posedge i_clk);
		i_rst_b <= 1'b1;
		settle();
		test_reset();
		test_pci();
		test_isa();
		test_crit();
		conclude();
	end
endmodule

// ===== rtl/cis_critical.sv
// critical error steering to the management and non-maskable outputs
`timescale 1ns/10ps
module cis_critical (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// sources and controls
	input wire logic [cis_pkg::SMI_SRC_COUNT-1:0] i_src,
	input wire logic [cis_pkg::SMI_SRC_COUNT-1:0] i_smi_en,
	input wire logic [cis_pkg::SMI_SRC_COUNT-1:0] i_nmi_map_en,
	// outputs
	output logic o_smi,
	output logic o_nmi
);
	logic smi_q, smi_d, nmi_q, nmi_d;

	// any enabled source raises the management interrupt
	always_comb begin
		smi_d = |(i_src & i_smi_en);
		// nmi path ignores smi enables so it works with the handler off
		nmi_d = |(i_src & i_nmi_map_en & cis_pkg::NMI_MAP_ALLOWED);
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			smi_q <= 1'b0;
			nmi_q <= 1'b0;
		end else begin
			smi_q <= smi_d;
			nmi_q <= nmi_d;
		end
	end

	assign o_smi = smi_q;
	assign o_nmi = nmi_q;

	chk_smi_follows_src: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		|(i_src & i_smi_en) |=> o_smi) else $error("smi missed enabled source");
	chk_nmi_no_smi_en: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_src[cis_pkg::SMI_PCI_SERR] && i_nmi_map_en[cis_pkg::SMI_PCI_SERR])
		|=> o_nmi) else $error("nmi missed serr");
	chk_nmi_corr_block: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_src == (7'h1 << cis_pkg::SMI_ECC_CORR)) |=> !o_nmi)
		else $error("correctable ecc made nmi");
endmodule

// ===== rtl/cis_pkg.sv
// shared constants for the critical interrupt steering block
package cis_pkg;
	localparam int ISA_INPUTS = 16;
	localparam int PCI_INPUTS = 49;
	localparam int ISA_INTR_POS = 0;
	localparam int ISA_IRQ1_POS = 1;
	localparam int ISA_IRQ0_POS = 2;
	localparam int ISA_IRQ8_POS = 8;
	localparam int PCI_HOTPLUG_POS = 43;
	localparam int PCI_SYSBUS_ERR_POS = 44;
	localparam int PCI_SB_NMI_POS = 46;
	localparam int PCI_UNUSED_POS = 47;
	localparam int SLOT_LINES = 4;
	localparam int SLOT_INPUTS = 43;
	localparam int NUM_VECTORS = 65;
	localparam int SMI_SRC_COUNT = 7;
	localparam int SMI_SB_NMI = 0;
	localparam int SMI_PCI_SERR = 1;
	localparam int SMI_PCI_PERR = 2;
	localparam int SMI_ECC_CORR = 3;
	localparam int SMI_ECC_UNCORR = 4;
	localparam int SMI_SB_SMI = 5;
	localparam int SMI_MGMT_SMI = 6;
	localparam logic [6:0] SMI_EN_RESET = 7'h3f;
	localparam logic [6:0] NMI_MAP_ALLOWED = 7'h56;
	typedef enum logic {CIS_MODE_CASCADE, CIS_MODE_APIC} cis_mode_e;
endpackage

// ===== rtl/cis_top.sv
// interrupt steering top: legacy/apic delivery plus critical error paths
`timescale 1ns/10ps
module cis_top #(
	parameter int ISA_N = cis_pkg::ISA_INPUTS,
	parameter int PCI_N = cis_pkg::PCI_INPUTS
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// interrupt inputs
	input wire logic [ISA_N-1:0] i_isa_irq,
	input wire logic [PCI_N-1:0] i_pci_int_b,
	// critical sources, active high
	input wire logic [cis_pkg::SMI_SRC_COUNT-1:0] i_crit_src,
	// configuration
	input wire logic i_apic_mode,
	input wire logic [cis_pkg::SMI_SRC_COUNT-1:0] i_smi_en,
	input wire logic [cis_pkg::SMI_SRC_COUNT-1:0] i_nmi_map_en,
	// legacy delivery
	output logic o_intr,
	output logic [7:0] o_intr_vector,
	// apic delivery
	output logic o_apic_valid,
	output logic [7:0] o_apic_vector,
	// pending view
	output logic [cis_pkg::NUM_VECTORS-1:0] o_pending,
	// critical outputs
	output logic o_system_management_interrupt,
	output logic o_nmi
);
	// the vector map fixes both input counts, so other values are refused
	if (ISA_N != cis_pkg::ISA_INPUTS || PCI_N != cis_pkg::PCI_INPUTS) begin : g_bad_cfg
		$error("cis_top: input counts are fixed by the vector map");
	end
	if (ISA_N + PCI_N != cis_pkg::NUM_VECTORS) begin : g_bad_map
		$error("cis_top: pending image must hold every input");
	end

	logic [cis_pkg::NUM_VECTORS-1:0] pend_d, pend_q;
	logic [ISA_N-1:0] isa_lvl;
	logic [PCI_N-1:0] pci_lvl;
	cis_pkg::cis_mode_e mode_d, mode_q;
	logic intr_d, intr_q, apic_v_d, apic_v_q;
	// vector choice plus the two registered delivery vectors
	logic [7:0] vec_d, intr_vec_d, apic_vec_d, intr_vec_q, apic_vec_q;

	// polarity fix per isa input; bit 8 arrives active low
	genvar gi;
	generate
		for (gi = 0; gi < ISA_N; gi++) begin : g_isa
			if (gi == cis_pkg::ISA_IRQ8_POS) begin : g_low
				assign isa_lvl[gi] = ~i_isa_irq[gi];
			end else begin : g_high
				assign isa_lvl[gi] = i_isa_irq[gi];
			end
		end
		// pci lines are active low levels; unused input is masked
		for (gi = 0; gi < PCI_N; gi++) begin : g_pci
			if (gi == cis_pkg::PCI_UNUSED_POS) begin : g_unused
				assign pci_lvl[gi] = 1'b0;
			end else begin : g_used
				assign pci_lvl[gi] = ~i_pci_int_b[gi];
			end
		end
	endgenerate

	// pending is a pure level image: no latch, so a source that drops
	// is forgotten, which matches level sharing-free slot lines
	always_comb begin
		pend_d = '0;
		pend_d[ISA_N-1:0] = isa_lvl;
		pend_d[ISA_N +: PCI_N] = pci_lvl;
		pend_d[0] = 1'b0; // input 0 is the cascade output itself, not a request
	end

	// pending image registered alone; reset clears every request
	// so no stale level is presented once reset lets go
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pend_q <= '0;
		end else begin
			pend_q <= pend_d;
		end
	end

	// lowest numbered pending vector wins; fixed priority keeps the
	// choice repeatable but a busy low line can starve higher ones
	always_comb begin
		vec_d = 8'h00;
		for (int k = cis_pkg::NUM_VECTORS - 1; k >= 0; k--) begin
			if (pend_q[k]) vec_d = 8'(k);
		end
		mode_d = i_apic_mode ? cis_pkg::CIS_MODE_APIC : cis_pkg::CIS_MODE_CASCADE;
		// cascade mode only presents the legacy group, apic all inputs
		intr_d = (mode_q == cis_pkg::CIS_MODE_CASCADE) && (|pend_q[ISA_N-1:1]);
		apic_v_d = (mode_q == cis_pkg::CIS_MODE_APIC) && (|pend_q);
		// an idle path shows vector zero rather than a stale number
		intr_vec_d = intr_d ? vec_d : 8'h00;
		apic_vec_d = apic_v_d ? vec_d : 8'h00;
	end

	// delivery state only registers what the block above decided
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mode_q <= cis_pkg::CIS_MODE_CASCADE;
			intr_q <= 1'b0;
			apic_v_q <= 1'b0;
			intr_vec_q <= 8'h00;
			apic_vec_q <= 8'h00;
		end else begin
			mode_q <= mode_d;
			intr_q <= intr_d;
			apic_v_q <= apic_v_d;
			intr_vec_q <= intr_vec_d;
			apic_vec_q <= apic_vec_d;
		end
	end

	assign o_intr = intr_q;
	assign o_intr_vector = intr_vec_q;
	assign o_apic_valid = apic_v_q;
	assign o_apic_vector = apic_vec_q;
	assign o_pending = pend_q;

	// south-bridge nmi pin also feeds the critical group
	logic [cis_pkg::SMI_SRC_COUNT-1:0] crit;
	always_comb begin
		crit = i_crit_src;
		crit[cis_pkg::SMI_SB_NMI] = i_crit_src[cis_pkg::SMI_SB_NMI] |
			pci_lvl[cis_pkg::PCI_SB_NMI_POS];
	end

	cis_critical u_crit (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_src(crit),
		.i_smi_en(i_smi_en),
		.i_nmi_map_en(i_nmi_map_en),
		.o_smi(o_system_management_interrupt),
		.o_nmi(o_nmi)
	);

	// slot lines: a low level is pending one edge later, a high one is not
	chk_slot_pending: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!i_pci_int_b[5] |=> o_pending[ISA_N + 5]) else $error("slot line not pending");
	chk_slot_release: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_pci_int_b[5] |=> !o_pending[ISA_N + 5]) else $error("slot line stuck");
	// legacy polarity and fixed positions
	chk_irq8_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!i_isa_irq[8] |=> o_pending[8]) else $error("irq8 polarity wrong");
	chk_irq8_high: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_isa_irq[8] |=> !o_pending[8]) else $error("irq8 idle seen as request");
	chk_irq0_level: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_isa_irq[cis_pkg::ISA_IRQ0_POS] |=> o_pending[cis_pkg::ISA_IRQ0_POS])
		else $error("irq0 input not pending");
	chk_irq1_level: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_isa_irq[cis_pkg::ISA_IRQ1_POS] |=> o_pending[cis_pkg::ISA_IRQ1_POS])
		else $error("irq1 input not pending");
	chk_isa0_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!o_pending[cis_pkg::ISA_INTR_POS]) else $error("intr slot seen as request");

	// fixed pci positions
	chk_unused_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!o_pending[ISA_N + 47]) else $error("unused input pending");
	chk_hotplug_pending: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!i_pci_int_b[cis_pkg::PCI_HOTPLUG_POS] |=> o_pending[ISA_N + cis_pkg::PCI_HOTPLUG_POS])
		else $error("hot-plug input not pending");
	chk_sysbus_pending: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!i_pci_int_b[cis_pkg::PCI_SYSBUS_ERR_POS] |=>
		o_pending[ISA_N + cis_pkg::PCI_SYSBUS_ERR_POS]) else $error("bus error input not pending");

	// two edges of a held request are needed: one registers the pending
	// image and the mode, the next registers the delivery output
	sequence s_apic_req3;
		i_apic_mode && !i_pci_int_b[3];
	endsequence
	sequence s_apic_req3_held;
		s_apic_req3 ##1 s_apic_req3;
	endsequence
	sequence s_cascade_irq3;
		!i_apic_mode && i_isa_irq[3];
	endsequence
	sequence s_cascade_irq3_held;
		s_cascade_irq3 ##1 s_cascade_irq3;
	endsequence

	// delivery: one mode at a time, and only what was pending
	chk_mode_excl: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!(o_intr && o_apic_valid)) else $error("both delivery modes active");
	chk_apic_deliver: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		s_apic_req3_held |=> o_apic_valid)
		else $error("apic delivery missing");
	chk_cascade_deliver: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		s_cascade_irq3_held |=> o_intr)
		else $error("cascade delivery missing");
	chk_cascade_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$past(o_pending[ISA_N-1:1]) == '0 |-> !o_intr) else $error("intr without legacy request");
	chk_apic_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$past(o_pending) == '0 |-> !o_apic_valid) else $error("apic valid with nothing pending");
	chk_apic_lowest: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_apic_valid && $past(o_pending[ISA_N + 4:0]) == '0 && $past(o_pending[ISA_N + 5]))
		|-> o_apic_vector == 8'h15)
		else $error("apic vector not lowest");

	// critical paths seen from the top pins
	chk_sb_nmi_smi: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(!i_pci_int_b[cis_pkg::PCI_SB_NMI_POS] && i_smi_en[cis_pkg::SMI_SB_NMI])
		|=> o_system_management_interrupt) else $error("south-bridge nmi pin missed smi");
	chk_smi_all_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_smi_en == '0 |=> !o_system_management_interrupt) else $error("smi with enables off");
	chk_uncorr_nmi: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_crit_src[cis_pkg::SMI_ECC_UNCORR] && i_nmi_map_en[cis_pkg::SMI_ECC_UNCORR] &&
		i_smi_en == '0) |=> o_nmi) else $error("nmi path needs smi enables");
	chk_nmi_refused: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_crit_src & cis_pkg::NMI_MAP_ALLOWED) == '0 |=> !o_nmi)
		else $error("nmi from a source that may not map");
endmodule
